// ==== core/rsc_radio_state_controller.sv ====
`timescale 1ns/1ps
`default_nettype none

module rsc_radio_state_controller
  import rsc_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Serial port
  input  wire logic             link_sclk,
  input  wire logic             cs_n,
  input  wire logic             mosi,
  output logic                  miso,
  // Configuration
  input  wire logic             skip_synth_cal,
  input  wire logic             rx_stream_mode,
  input  wire logic             tx_stream_mode,
  input  wire logic             rx_search_en,
  input  wire logic [7:0]       rx_delay,
  input  wire logic [7:0]       tx_delay,
  input  wire logic [3:0]       sleep_config,
  input  wire logic             wake_ctrl_en,
  input  wire logic             wake_timeout,
  // Datapath events
  input  wire logic             syscal_done,
  input  wire logic             synth_cal_done,
  input  wire logic             rx_packet_done,
  input  wire logic             tx_packet_done,
  input  wire logic             cca_done,
  input  wire logic             adc_valid,
  input  wire logic [ADC_W-1:0] adc_sample,
  // Status and control
  output rsc_state_t            radio_state,
  output rsc_pwr_t              power,
  output rsc_evt_t              events,
  output logic [ADC_W-1:0]      adc_out
);

  // ==========================================================================
  // Helpers
  function automatic logic is_awake(input rsc_state_t s);
    return (s == ST_IDLE) || (s == ST_RDY) || (s == ST_RX) ||
           (s == ST_TX) || (s == ST_CCA) || (s == ST_TEMP);
  endfunction

  function automatic logic sleep_valid(input logic [3:0] c);
    return (c == SLEEP_BACKUP_ONLY) || (c == SLEEP_WITH_CRYSTAL_TIMER) ||
           (c == SLEEP_WITH_RC_TIMER);
  endfunction

  // ==========================================================================
  // Link side: byte capture on the serial clock
  rsc_spi_t  spi_r, spi_nxt;
  rsc_hand_t hand_r, hand_nxt;

  always_comb begin
    spi_nxt        = spi_r;
    hand_nxt       = hand_r;
    spi_nxt.bitcnt = spi_r.bitcnt + 3'h1;
    spi_nxt.shift  = {spi_r.shift[5:0], mosi};
    if (spi_r.bitcnt == 3'h7) begin
      hand_nxt.cmd = {spi_r.shift, mosi};
      hand_nxt.tog = ~hand_r.tog;
    end
  end

  // Frame end clears the bit position, since the clock stops between frames
  always_ff @(posedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      spi_r <= '0;
    end else begin
      spi_r <= spi_nxt;
    end
  end

  always_ff @(posedge link_sclk or posedge reset) begin
    if (reset) begin
      hand_r <= '0;
    end else begin
      hand_r <= hand_nxt;
    end
  end

  // ==========================================================================
  // Core side state
  typedef struct packed {
    rsc_state_t       state;
    rsc_phase_t       ph;
    rsc_state_t       cca_ret;
    logic [15:0]      cnt;
    logic [3:0]       sleep_mode;
    logic [1:0]       cs_sync;
    logic             cs_prev;
    logic [1:0]       wto_sync;
    logic             wto_prev;
    logic [1:0]       tog_sync;
    logic             tog_prev;
    logic             miso;
    rsc_pwr_t         pwr;
    rsc_evt_t         evt;
    logic [ADC_W-1:0] adc;
  } rsc_ctl_t;

  rsc_ctl_t r, n;

  logic       cs_fall;
  logic       wto_rise;
  logic       cmd_new;
  logic       taken;
  logic [7:0] cmd;

  always_comb begin
    n        = r;
    n.evt    = '0;
    taken    = 1'b0;
    cmd      = hand_r.cmd;
    cs_fall  = r.cs_prev & ~r.cs_sync[1];
    wto_rise = r.wto_sync[1] & ~r.wto_prev;
    cmd_new  = r.tog_sync[1] ^ r.tog_prev;

    n.cs_sync  = {r.cs_sync[0], cs_n};
    n.cs_prev  = r.cs_sync[1];
    n.wto_sync = {r.wto_sync[0], wake_timeout};
    n.wto_prev = r.wto_sync[1];
    n.tog_sync = {r.tog_sync[0], hand_r.tog};
    n.tog_prev = r.tog_sync[1];

    if (r.cnt != 16'h0000) begin
      n.cnt = r.cnt - 16'h0001;
    end

    if (cmd_new && is_awake(r.state)) begin
      unique case (cmd)
        CMD_RESET_SHUTDOWN: begin
          taken   = 1'b1;
          n.state = ST_OFF;
          n.ph    = PH_RUN;
        end
        CMD_GO_IDLE: begin
          taken   = 1'b1;
          n.state = ST_IDLE;
          n.ph    = PH_RUN;
        end
        CMD_SYNTH_READY: begin
          if (r.state inside {ST_IDLE, ST_RX, ST_TX, ST_CCA}) begin
            taken   = 1'b1;
            n.state = ST_RDY;
            if (r.state == ST_IDLE) begin
              n.ph               = PH_CAL;
              n.evt.syscal_start = 1'b1;
            end else begin
              n.ph = PH_RUN;
            end
          end
        end
        CMD_RECEIVE: begin
          if (r.state inside {ST_RDY, ST_CCA, ST_TX}) begin
            taken   = 1'b1;
            n.state = ST_RX;
            if ((r.state != ST_CCA) && !skip_synth_cal) begin
              n.ph                  = PH_CAL;
              n.evt.synth_cal_start = 1'b1;
            end else begin
              n.ph  = PH_WAIT;
              n.cnt = {8'h00, rx_delay};
            end
          end
        end
        CMD_TRANSMIT: begin
          if (r.state inside {ST_RDY, ST_RX}) begin
            taken   = 1'b1;
            n.state = ST_TX;
            if (!skip_synth_cal) begin
              n.ph                  = PH_CAL;
              n.evt.synth_cal_start = 1'b1;
            end else begin
              n.ph  = PH_WAIT;
              n.cnt = {8'h00, tx_delay};
            end
          end
        end
        CMD_CHANNEL_ASSESS: begin
          if (r.state inside {ST_RDY, ST_RX}) begin
            taken           = 1'b1;
            n.state         = ST_CCA;
            n.ph            = PH_RUN;
            n.cca_ret       = r.state;
            n.evt.cca_start = 1'b1;
          end
        end
        CMD_MEASURE_TEMP: begin
          if (r.state == ST_IDLE) begin
            taken   = 1'b1;
            n.state = ST_TEMP;
            n.ph    = PH_RUN;
          end
        end
        CMD_SLEEP: begin
          if (sleep_valid(sleep_config)) begin
            taken        = 1'b1;
            n.state      = ST_SLEEP;
            n.ph         = PH_RUN;
            n.sleep_mode = sleep_config;
          end
        end
        default: begin
          taken = 1'b0;
        end
      endcase
      n.evt.cmd_ignored = ~taken;
    end else begin
      unique case (r.state)
        ST_OFF: begin
          if (cs_fall) begin
            n.state = ST_POR;
            n.cnt   = WAKE_CYCLES - 16'h0001;
          end
        end
        ST_SLEEP: begin
          if (cs_fall || (wake_ctrl_en && wto_rise)) begin
            n.state = ST_WAKE;
            n.cnt   = WAKE_CYCLES - 16'h0001;
          end
        end
        ST_POR, ST_WAKE: begin
          if (r.cnt == 16'h0000) begin
            n.state             = ST_IDLE;
            n.ph                = PH_RUN;
            n.evt.load_defaults = 1'b1;
          end
        end
        ST_RDY: begin
          if ((r.ph == PH_CAL) && syscal_done) begin
            n.ph = PH_RUN;
          end
        end
        ST_RX: begin
          if ((r.ph == PH_CAL) && synth_cal_done) begin
            n.ph  = PH_WAIT;
            n.cnt = {8'h00, rx_delay};
          end else if ((r.ph == PH_WAIT) && (r.cnt == 16'h0000)) begin
            n.ph = PH_RUN;
          end else if ((r.ph == PH_RUN) && rx_packet_done && !rx_stream_mode) begin
            n.state = ST_RDY;
          end
        end
        ST_TX: begin
          if ((r.ph == PH_CAL) && synth_cal_done) begin
            n.ph  = PH_WAIT;
            n.cnt = {8'h00, tx_delay};
          end else if ((r.ph == PH_WAIT) && (r.cnt == 16'h0000)) begin
            n.ph = PH_RUN;
          end else if ((r.ph == PH_RUN) && tx_packet_done && !tx_stream_mode) begin
            n.state = ST_RDY;
          end
        end
        ST_CCA: begin
          if (cca_done) begin
            n.state = r.cca_ret;
            n.ph    = PH_RUN;
          end
        end
        ST_IDLE, ST_TEMP: begin
          n.ph = PH_RUN;
        end
      endcase
    end

    if ((r.state == ST_TEMP) && adc_valid) begin
      n.adc = adc_sample;
    end

    // Power and retention follow the next state
    n.pwr = '0;
    unique case (n.state)
      ST_OFF: begin
        n.pwr = '0;
      end
      ST_SLEEP: begin
        n.pwr.backup_mem_en        = 1'b1;
        n.pwr.wake_timer_cfg_clear = 1'b1;
        n.pwr.xto32k_en            = (n.sleep_mode == SLEEP_WITH_CRYSTAL_TIMER);
        n.pwr.rco32k_en            = (n.sleep_mode == SLEEP_WITH_RC_TIMER);
      end
      ST_POR, ST_WAKE: begin
        n.pwr.ldo_en        = 1'b1;
        n.pwr.xtal26_en     = 1'b1;
        n.pwr.core_en       = 1'b1;
        n.pwr.backup_mem_en = 1'b1;
      end
      ST_IDLE, ST_RDY, ST_RX, ST_TX, ST_CCA, ST_TEMP: begin
        n.pwr.ldo_en          = 1'b1;
        n.pwr.xtal26_en       = 1'b1;
        n.pwr.core_en         = 1'b1;
        n.pwr.backup_mem_en   = 1'b1;
        n.pwr.packet_mem_keep = 1'b1;
        n.pwr.modem_cfg_keep  = 1'b1;
        n.pwr.synth_en        = n.state inside {ST_RDY, ST_RX, ST_TX, ST_CCA};
        n.pwr.rx_en           = n.state inside {ST_RX, ST_CCA};
        n.pwr.tx_en           = (n.state == ST_TX);
        n.pwr.preamble_search = (n.state == ST_RX) && (n.ph == PH_RUN) && rx_search_en;
        n.pwr.pa_ramp         = (n.state == ST_TX) && (n.ph == PH_RUN);
        n.pwr.temp_adc_en     = (n.state == ST_TEMP);
      end
    endcase

    n.miso = ~r.cs_sync[1] & is_awake(r.state);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r          <= '0;
      r.state    <= ST_OFF;
      r.ph       <= PH_RUN;
      r.cca_ret  <= ST_RDY;
      r.cs_sync  <= 2'h3;
      r.cs_prev  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign miso        = r.miso;
  assign radio_state = r.state;
  assign power       = r.pwr;
  assign events      = r.evt;
  assign adc_out     = r.adc;

endmodule // rsc_radio_state_controller

`default_nettype wire

// ==== core/rsc_pkg.sv ====
package rsc_pkg;

  // ==========================================================================
  // Command bytes (values are arbitrary)
  localparam logic [7:0] CMD_RESET_SHUTDOWN = 8'h01;
  localparam logic [7:0] CMD_GO_IDLE        = 8'h02;
  localparam logic [7:0] CMD_SYNTH_READY    = 8'h03;
  localparam logic [7:0] CMD_RECEIVE        = 8'h04;
  localparam logic [7:0] CMD_TRANSMIT       = 8'h05;
  localparam logic [7:0] CMD_CHANNEL_ASSESS = 8'h06;
  localparam logic [7:0] CMD_MEASURE_TEMP   = 8'h07;
  localparam logic [7:0] CMD_SLEEP          = 8'h08;

  // ==========================================================================
  // Sleep flavours
  localparam logic [3:0] SLEEP_BACKUP_ONLY        = 4'h1;
  localparam logic [3:0] SLEEP_WITH_CRYSTAL_TIMER = 4'h5;
  localparam logic [3:0] SLEEP_WITH_RC_TIMER      = 4'hB;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          WAKE_TIME_NS  = 1000;
  localparam logic [15:0] WAKE_CYCLES   = 16'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          ADC_W         = 10;

  // ==========================================================================
  // States and phases
  typedef enum logic [9:0] {
    ST_OFF   = 10'h001,
    ST_POR   = 10'h002,
    ST_SLEEP = 10'h004,
    ST_WAKE  = 10'h008,
    ST_IDLE  = 10'h010,
    ST_RDY   = 10'h020,
    ST_RX    = 10'h040,
    ST_TX    = 10'h080,
    ST_CCA   = 10'h100,
    ST_TEMP  = 10'h200
  } rsc_state_t;

  typedef enum logic [2:0] {
    PH_CAL  = 3'h1,
    PH_WAIT = 3'h2,
    PH_RUN  = 3'h4
  } rsc_phase_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic ldo_en;
    logic xtal26_en;
    logic core_en;
    logic synth_en;
    logic rx_en;
    logic tx_en;
    logic pa_ramp;
    logic preamble_search;
    logic temp_adc_en;
    logic backup_mem_en;
    logic packet_mem_keep;
    logic modem_cfg_keep;
    logic xto32k_en;
    logic rco32k_en;
    logic wake_timer_cfg_clear;
  } rsc_pwr_t;

  typedef struct packed {
    logic load_defaults;
    logic syscal_start;
    logic synth_cal_start;
    logic cca_start;
    logic cmd_ignored;
  } rsc_evt_t;

  typedef struct packed {
    logic [2:0] bitcnt;
    logic [6:0] shift;
  } rsc_spi_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic       tog;
  } rsc_hand_t;

endpackage

// ==== testbench/rsc_radio_state_controller_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module rsc_radio_state_controller_properties
  import rsc_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Watched inputs
  input  wire logic             cs_n,
  input  wire logic             skip_synth_cal,
  input  wire logic [3:0]       sleep_config,
  input  wire logic             adc_valid,
  input  wire logic [ADC_W-1:0] adc_sample,
  // Watched outputs
  input  wire logic             miso,
  input  wire rsc_state_t       radio_state,
  input  wire rsc_pwr_t         power,
  input  wire rsc_evt_t         events,
  input  wire logic [ADC_W-1:0] adc_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Properties
  property p_por_power; radio_state == ST_POR |-> power.ldo_en && power.xtal26_en && power.core_en; endproperty
  a_por_power: assert property (p_por_power) else $error("power-up supplies off");
  property p_por_exit; $past(radio_state) == ST_POR && radio_state != ST_POR |-> radio_state == ST_IDLE && events.load_defaults; endproperty
  a_por_exit: assert property (p_por_exit) else $error("power-up did not end in idle");
  property p_awake_ready;
    $fell(cs_n) && radio_state inside {ST_IDLE, ST_RDY, ST_RX, ST_TX, ST_CCA, ST_TEMP} |-> ##[1:6] miso;
  endproperty
  a_awake_ready: assert property (p_awake_ready) else $error("ready flag late");
  property p_sleep_wake; radio_state == ST_SLEEP && $fell(cs_n) |-> ##[1:6] radio_state == ST_WAKE; endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("select did not wake");
  property p_idle_power; radio_state == ST_IDLE |-> !power.rx_en && !power.tx_en && power.core_en; endproperty
  a_idle_power: assert property (p_idle_power) else $error("idle power wrong");
  property p_adc; radio_state == ST_TEMP && adc_valid |=> adc_out == $past(adc_sample); endproperty
  a_adc: assert property (p_adc) else $error("reading not loaded");
  property p_sleep_power;
    radio_state == ST_SLEEP |-> power.wake_timer_cfg_clear && power.backup_mem_en && !power.packet_mem_keep
      && !power.modem_cfg_keep;
  endproperty
  a_sleep_power: assert property (p_sleep_power) else $error("sleep retention wrong");
  property p_flavour;
    $rose(radio_state == ST_SLEEP) |-> power.xto32k_en == ($past(sleep_config) == SLEEP_WITH_CRYSTAL_TIMER)
      && power.rco32k_en == ($past(sleep_config) == SLEEP_WITH_RC_TIMER);
  endproperty
  a_flavour: assert property (p_flavour) else $error("sleep flavour wrong");
  property p_syscal; $rose(radio_state == ST_RDY) |-> events.syscal_start == ($past(radio_state) == ST_IDLE); endproperty
  a_syscal: assert property (p_syscal) else $error("system calibration wrong");
  property p_ignored; events.cmd_ignored |-> radio_state == $past(radio_state); endproperty
  a_ignored: assert property (p_ignored) else $error("ignored command moved state");
  property p_tx_cal; $rose(radio_state == ST_TX) |-> events.synth_cal_start == !$past(skip_synth_cal); endproperty
  a_tx_cal: assert property (p_tx_cal) else $error("transmit calibration wrong");
  property p_rx_cal;
    $rose(radio_state == ST_RX) && $past(radio_state) != ST_CCA |-> events.synth_cal_start == !$past(skip_synth_cal);
  endproperty
  a_rx_cal: assert property (p_rx_cal) else $error("receive calibration wrong");
  property p_cca; $rose(radio_state == ST_CCA) |-> events.cca_start; endproperty
  a_cca: assert property (p_cca) else $error("assessment not started");

  cp_tx: cover property ($rose(radio_state == ST_TX));
  cp_temp: cover property (radio_state == ST_TEMP && adc_valid);
  cp_wake: cover property ($rose(radio_state == ST_WAKE));
endmodule // rsc_radio_state_controller_properties

bind rsc_radio_state_controller rsc_radio_state_controller_properties i_rsc_radio_state_controller_properties (
  .ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .skip_synth_cal(skip_synth_cal), .sleep_config(sleep_config),
  .adc_valid(adc_valid), .adc_sample(adc_sample), .miso(miso), .radio_state(radio_state), .power(power),
  .events(events), .adc_out(adc_out));

`default_nettype wire

// ==== testbench/rsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Host side of the serial port
module rsc_host_model (
  // Serial port
  output logic      link_sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    link_sclk = 1'b0;
    // Late update gives a real rising edge, so the bit position clears at start
    cs_n     <= 1'b1;
    mosi      = 1'b0;
  end

  // One command per frame; the link clock only runs inside a frame
  task automatic frame(input logic [7:0] b, output logic ok);
    #37 cs_n = 1'b0;
    for (int n = 0; n < 400 && miso !== 1'b1; n++) #10;
    ok = (miso === 1'b1);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #80 link_sclk = 1'b1;
      #80 link_sclk = 1'b0;
    end
    mosi = !b[0];
    #80 cs_n = 1'b1;
    #300;
  endtask
endmodule // rsc_host_model

`default_nettype wire

// ==== testbench/tb_radio_state_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end

module tb_radio_state_controller
  import rsc_pkg::*;
;
  logic             ref_clk = 1'b0;
  logic             reset = 1'b0;
  logic             link_sclk, cs_n, mosi, miso, ok;
  logic             skip = 1'b0, rxs = 1'b0, txs = 1'b0, srch = 1'b0, wce = 1'b0, wto = 1'b0, adc_v = 1'b0;
  logic [7:0]       rxd = 8'h00, txd = 8'h00, c;
  logic [3:0]       sc = 4'h1;
  logic [4:0]       ev = 5'h00;
  logic [ADC_W-1:0] adc_s = '0, adc_o;
  rsc_state_t       radio_state, ms, org;
  rsc_pwr_t         power;
  rsc_evt_t         events;
  int               seed = 32'h47B97370;
  int               mismatches = 0;
  int               check_count = 0;
  logic [7:0]       ctab [12] = '{CMD_SYNTH_READY, CMD_RECEIVE, CMD_TRANSMIT, CMD_CHANNEL_ASSESS, CMD_SYNTH_READY,
                                  CMD_RECEIVE, CMD_GO_IDLE, CMD_MEASURE_TEMP, CMD_SLEEP, CMD_RESET_SHUTDOWN, 8'h00,
                                  CMD_TRANSMIT};
  logic [3:0]       stab [4] = '{4'h1, 4'h5, 4'hB, 4'h3};

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  rsc_radio_state_controller i_rsc_radio_state_controller (
    .ref_clk(ref_clk), .reset(reset), .link_sclk(link_sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .skip_synth_cal(skip), .rx_stream_mode(rxs), .tx_stream_mode(txs), .rx_search_en(srch), .rx_delay(rxd),
    .tx_delay(txd), .sleep_config(sc), .wake_ctrl_en(wce), .wake_timeout(wto), .syscal_done(ev[0]),
    .synth_cal_done(ev[1]), .rx_packet_done(ev[2]), .tx_packet_done(ev[3]), .cca_done(ev[4]), .adc_valid(adc_v),
    .adc_sample(adc_s), .radio_state(radio_state), .power(power), .events(events), .adc_out(adc_o));

  rsc_host_model i_rsc_host_model (.link_sclk(link_sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // ==========================================================================
  // Reference model
  function automatic rsc_state_t nxt(rsc_state_t s, logic [7:0] k);
    case (k)
      CMD_RESET_SHUTDOWN: return ST_OFF;
      CMD_GO_IDLE:        return ST_IDLE;
      CMD_SYNTH_READY:    return (s inside {ST_IDLE, ST_RX, ST_TX, ST_CCA}) ? ST_RDY : s;
      CMD_RECEIVE:        return (s inside {ST_RDY, ST_CCA, ST_TX}) ? ST_RX : s;
      CMD_TRANSMIT:       return (s inside {ST_RDY, ST_RX}) ? ST_TX : s;
      CMD_CHANNEL_ASSESS: return (s inside {ST_RDY, ST_RX}) ? ST_CCA : s;
      CMD_MEASURE_TEMP:   return (s == ST_IDLE) ? ST_TEMP : s;
      CMD_SLEEP:          return (sc inside {SLEEP_BACKUP_ONLY, SLEEP_WITH_CRYSTAL_TIMER, SLEEP_WITH_RC_TIMER}) ?
                                 ST_SLEEP : s;
      default:            return s;
    endcase
  endfunction

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge ref_clk);
    ev <= 5'h00;
    @(posedge ref_clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    // Rising edge of reset also clears the link-side hand-over flop
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    `CHK(radio_state, ST_OFF)
    ms = ST_OFF;
    for (int it = 0; it < 120; it++) begin
      c = ctab[$unsigned($random(seed)) % 12];
      if (ms == ST_IDLE) begin
        sc <= stab[2'($random(seed))];
        {skip, rxs, txs, srch, wce} <= 5'($random(seed));
        rxd <= 8'($random(seed) & 7);
        txd <= 8'($random(seed) & 7);
      end
      @(posedge ref_clk);
      i_rsc_host_model.frame(c, ok);
      `CHK(ok, 1'b1)
      repeat (8) @(posedge ref_clk);
      if (ms inside {ST_OFF, ST_SLEEP}) ms = ST_IDLE;
      if (c == CMD_CHANNEL_ASSESS && ms inside {ST_RDY, ST_RX}) org = ms;
      ms = nxt(ms, c);
      `CHK(radio_state, ms)
      case (ms)
        ST_OFF:  `CHK(power, rsc_pwr_t'(0))
        ST_IDLE: `CHK({power.rx_en, power.tx_en, power.core_en}, 3'b001)
        ST_TEMP: begin
          adc_s <= ADC_W'($random(seed));
          adc_v <= 1'b1;
          @(posedge ref_clk);
          adc_v <= 1'b0;
          repeat (2) @(posedge ref_clk);
          `CHK(adc_o, adc_s)
        end
        ST_SLEEP: begin
          `CHK({power.xto32k_en, power.rco32k_en}, {sc == SLEEP_WITH_CRYSTAL_TIMER, sc == SLEEP_WITH_RC_TIMER})
          `CHK({power.wake_timer_cfg_clear, power.packet_mem_keep, power.modem_cfg_keep}, 3'b100)
          wto <= 1'b1;
          repeat (130) @(posedge ref_clk);
          wto <= 1'b0;
          if (wce) ms = ST_IDLE;
          `CHK(radio_state, ms)
        end
        default: begin
          pulse(0);
          pulse(1);
          repeat (20) @(posedge ref_clk);
          if (ms == ST_RX) `CHK(power.preamble_search, srch)
          if (ms == ST_TX) `CHK(power.pa_ramp, 1'b1)
          pulse(ms == ST_CCA ? 4 : ms == ST_RX ? 2 : 3);
          repeat (3) @(posedge ref_clk);
          if (ms == ST_CCA) ms = org;
          else if ((ms == ST_RX && !rxs) || (ms == ST_TX && !txs)) ms = ST_RDY;
          `CHK(radio_state, ms)
        end
      endcase
      $display("step %0d cmd %0h state %0h", it, c, ms);
    end
    wrap_up();
  end

  initial begin
    #900_000;
    mismatches++;
    wrap_up();
  end
endmodule // tb_radio_state_controller

`default_nettype wire
